// ===== rtl/frs_consts.vh
`ifndef FRS_CONSTS_VH
`define FRS_CONSTS_VH
// Host I/O addresses (10-bit ISA decode)
`define FRS_ADDR_RATE_CFG     10'h3F7
`define FRS_ADDR_DATA         10'h3F5
// Register mode select bits of configuration byte
`define FRS_MODE_STD_BIT      6
`define FRS_MODE_EXT_BIT      5
// Register mode codes
`define FRS_MODE_STD          2'h0
`define FRS_MODE_EXT          2'h1
`define FRS_MODE_CMP          2'h2
// Rate code values and hardware reset value (250 Kbps)
`define FRS_RATE_500K         2'h0
`define FRS_RATE_300K         2'h1
`define FRS_RATE_250K         2'h2
`define FRS_RATE_1M           2'h3
`define FRS_RATE_RESET        2'h2
// Decoded rate setting to data separator (one-hot)
`define FRS_SEP_500K          4'h1
`define FRS_SEP_300K          4'h2
`define FRS_SEP_250K          4'h4
`define FRS_SEP_1M            4'h8
// Rate configuration field positions
`define FRS_CFG_RATE_HI       1
`define FRS_CFG_RATE_LO       0
`define FRS_CFG_PRECOMP       2
// Digital output register request gate bit
`define FRS_DOR_GATE_BIT      3
// Completion codes
`define FRS_CC_NORMAL         2'h0
`define FRS_CC_ABNORMAL       2'h1
`define FRS_CC_INVALID        2'h2
`define FRS_CC_POLLING        2'h3
// Recalibrate step limit
`define FRS_RECAL_STEPS       7'h50
// Number of result bytes returned
`define FRS_RESULT_COUNT      2'h2
`endif

// ===== rtl/frs_rate_status_regs.v
// Behaviour
// - Extended mode bits 1-2 show rate code
// - Extended mode bits 3-6 read one
// - Bit 7 is inverted media swapped
// - Compact mode bits 4-6 read zero
// - Compact bit 2 shows precomp flag
// - Compact bit 3 shows request gate
// - Compact bits 0-1 show rate code
// - Write 3F7 loads rate, reset 250K
// - Precomp flag stored in compact mode only, survives soft reset
// - Density out high on hardware reset
// - Status zero bits 7-6 completion code
// - Status zero bit 5 positioning done
// - Status zero bit 4 drive fault
// - Status zero head and unit number
// - Status one bit 7 end of track
// - Status one bit 5 CRC fault
// - Status one bit 4 overrun
// - Status one bit 2 sector absent
// - Status one bit 1 write blocked
// - Status one bit 0 no sync pattern
// - Unused status bits read zero
// - Config bits 6,5 choose register mode
// - Input status read at 3F7 only
`include "frs_consts.vh"

module frs_rate_status_regs (
	input  wire       i_sys_clk,            // System clock, 25 MHz
	input  wire       i_reset_n,            // Hardware reset, active low
	input  wire       i_clk_en,             // Clock enable, freezes state when low
	input  wire       i_soft_reset,         // Software reset pulse (output or rate reg)
	input  wire [9:0] i_io_addr,            // ISA address
	input  wire       i_io_rd_n,            // ISA read strobe, active low
	input  wire       i_io_wr_n,            // ISA write strobe, active low
	input  wire [7:0] i_io_wdata,           // ISA write data
	output reg  [7:0] o_io_rdata,           // ISA read data
	output wire       o_io_rdata_oe,        // Read data drive enable
	input  wire [7:0] i_config_mode,        // Configuration byte with mode bits
	input  wire       i_request_gate_flag,  // Gate bit of digital output register
	input  wire       i_media_swapped,      // Drive cable media swapped pin
	output reg        o_density_out,        // Density select output
	output reg  [3:0] o_rate_setting,       // Decoded rate for data separator
	output wire [1:0] o_register_mode,      // Active register mode
	input  wire       i_exec_done,          // Command execution finished pulse
	input  wire [1:0] i_completion_code,    // Completion code
	input  wire       i_positioning_done,   // Seek or recalibrate done
	input  wire       i_recal_active,       // Recalibrate in progress
	input  wire       i_step_pulse,         // One step pulse issued
	input  wire       i_track_zero_in,      // Track zero pin
	input  wire       i_seek_past_zero,     // Relative seek past track zero
	input  wire       i_head,               // Current head
	input  wire [1:0] i_unit_number,        // Selected drive
	input  wire       i_sector_beyond,      // Access beyond final sector
	input  wire       i_data_cmd,           // Read or write data command ended
	input  wire       i_transfer_end_in,    // Terminal count seen
	input  wire       i_crc_fault,          // CRC error
	input  wire       i_overrun,            // Service too late
	input  wire       i_sector_absent,      // Sector not found
	input  wire       i_write_cmd,          // Write or format command running
	input  wire       i_write_protect_in,   // Write protect pin
	input  wire       i_no_sync_pattern,    // Address mark missing
	output wire       o_result_ready        // Result bytes waiting for host
);
	// Reset release synchroniser
	reg  [1:0] rst_sync;                    // Reset release stages
	wire       rst_n;                       // Synchronised reset
	// Pin synchronisers, first stage read only by second
	reg  [1:0] swap_sync;                   // Media swapped stages
	reg  [1:0] track_zero_in_sync;                   // Track zero stages
	reg  [1:0] wp_sync;                     // Write protect stages
	reg  [1:0] rd_sync;                     // Read strobe stages
	reg  [1:0] wr_sync;                     // Write strobe stages
	reg        wr_prev;                     // Previous write level for edge
	reg        rd_prev;                     // Previous read level for edge
	// Stored state
	reg  [1:0] rate_code;                   // Current rate code
	reg        precomp_off_flag;            // Stored, no effect
	reg        rate_wr_d;                   // Rate write landed last cycle
	reg  [6:0] step_count;                  // Recalibrate step counter
	reg        drive_fault_flag;            // Track zero never seen, or seek past track zero
	reg        write_blocked;               // Write protect during write
	reg  [7:0] result_zero;                 // Latched status byte 0
	reg  [7:0] result_one;                  // Latched status byte 1
	reg  [1:0] result_left;                 // Result bytes still to read
	wire [7:0] pack_zero;                   // Packed status byte 0
	wire [7:0] pack_one;                    // Packed status byte 1
	wire       wr_pulse;                    // Host write event
	wire       rd_pulse;                    // Host read event
	wire       end_of_track;                // Status one bit 7 cause

	// Mode decode used by status view and mode output
	function [1:0] mode_of;
		input [7:0] cfg;
		begin
			if (cfg[`FRS_MODE_STD_BIT])
				mode_of = `FRS_MODE_STD;
			else if (cfg[`FRS_MODE_EXT_BIT])
				mode_of = `FRS_MODE_EXT;
			else
				mode_of = `FRS_MODE_CMP;
		end
	endfunction

	assign o_register_mode = mode_of(i_config_mode);

	// Reset release through two flops, assert stays asynchronous
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// Two-flop synchronisers for pins and strobes
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			swap_sync <= 2'h0;
			track_zero_in_sync <= 2'h0;
			wp_sync   <= 2'h0;
			rd_sync   <= 2'h3;
			wr_sync   <= 2'h3;
			wr_prev   <= 1'b1;
			rd_prev   <= 1'b1;
		end else if (i_clk_en) begin
			swap_sync <= {swap_sync[0], i_media_swapped};
			track_zero_in_sync <= {track_zero_in_sync[0], i_track_zero_in};
			wp_sync   <= {wp_sync[0], i_write_protect_in};
			rd_sync   <= {rd_sync[0], i_io_rd_n};
			wr_sync   <= {wr_sync[0], i_io_wr_n};
			wr_prev   <= wr_sync[1];
			rd_prev   <= rd_sync[1];
		end
	end

	// Strobe falling edges count as one access
	assign wr_pulse = wr_prev & ~wr_sync[1];
	assign rd_pulse = rd_prev & ~rd_sync[1];

	// Rate configuration write; soft reset deliberately not in the list
	// so rate and precomp flag survive it
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_code        <= `FRS_RATE_RESET;
			precomp_off_flag <= 1'b0;
			rate_wr_d        <= 1'b0;
		end else if (i_clk_en) begin
			rate_wr_d <= wr_pulse && (i_io_addr == `FRS_ADDR_RATE_CFG);
			if (wr_pulse && i_io_addr == `FRS_ADDR_RATE_CFG) begin
				// Reserved upper bits are assumed zero and ignored
				rate_code <= {i_io_wdata[`FRS_CFG_RATE_HI], i_io_wdata[`FRS_CFG_RATE_LO]};
				if (o_register_mode == `FRS_MODE_CMP)
					precomp_off_flag <= i_io_wdata[`FRS_CFG_PRECOMP];
			end
		end
	end

	// Density output: high from hardware reset until the host writes a rate,
	// so the pin does not drop on its own when reset ends
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n)
			o_density_out <= 1'b1;
		else if (i_clk_en && rate_wr_d)
			o_density_out <= (rate_code == `FRS_RATE_500K) || (rate_code == `FRS_RATE_1M);
	end

	// Rate decode for the data separator
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n)
			o_rate_setting <= `FRS_SEP_250K;
		else if (i_clk_en) begin
			case (rate_code)
			`FRS_RATE_500K: o_rate_setting <= `FRS_SEP_500K;
			`FRS_RATE_300K: o_rate_setting <= `FRS_SEP_300K;
			`FRS_RATE_250K: o_rate_setting <= `FRS_SEP_250K;
			default:        o_rate_setting <= `FRS_SEP_1M;
			endcase
		end
	end

	// Recalibrate step counting and fault capture; set wins over clear
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_count       <= 7'h00;
			drive_fault_flag <= 1'b0;
			write_blocked    <= 1'b0;
		end else if (i_clk_en) begin
			if (!i_recal_active || track_zero_in_sync[1])
				step_count <= 7'h00;
			else if (i_step_pulse && step_count != `FRS_RECAL_STEPS)
				step_count <= step_count + 7'h01;
			if ((i_recal_active && !track_zero_in_sync[1] && step_count == `FRS_RECAL_STEPS) || i_seek_past_zero)
				drive_fault_flag <= 1'b1;
			else if (i_soft_reset || (rd_pulse && i_io_addr == `FRS_ADDR_DATA && result_left == 2'h1))
				drive_fault_flag <= 1'b0;
			if (i_write_cmd && wp_sync[1])
				write_blocked <= 1'b1;
			else if (i_soft_reset || (rd_pulse && i_io_addr == `FRS_ADDR_DATA && result_left == 2'h1))
				write_blocked <= 1'b0;
		end
	end

	// Past final sector, or missing end count after a data command
	assign end_of_track = i_sector_beyond | (i_data_cmd & ~i_transfer_end_in);

	frs_status_pack u_pack (
		.i_completion_code  (i_completion_code),
		.i_positioning_done (i_positioning_done),
		.i_drive_fault_flag (drive_fault_flag),
		.i_head             (i_head),
		.i_unit_number      (i_unit_number),
		.i_end_of_track     (end_of_track),
		.i_crc_fault        (i_crc_fault),
		.i_overrun          (i_overrun),
		.i_sector_absent    (i_sector_absent),
		.i_write_blocked    (write_blocked),
		.i_no_sync_pattern  (i_no_sync_pattern),
		.o_status_zero      (pack_zero),
		.o_status_one       (pack_one)
	);

	// Result latch at end of execution, drained byte 0 then byte 1
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_zero <= 8'h00;
			result_one  <= 8'h00;
			result_left <= 2'h0;
		end else if (i_clk_en) begin
			if (i_soft_reset)
				result_left <= 2'h0;
			else if (i_exec_done) begin
				result_zero <= pack_zero;
				result_one  <= pack_one;
				result_left <= `FRS_RESULT_COUNT;
			end else if (rd_pulse && i_io_addr == `FRS_ADDR_DATA && result_left != 2'h0)
				result_left <= result_left - 2'h1;
		end
	end
	assign o_result_ready = (result_left != 2'h0);

	// Read data mux, captured once per read so a result byte stands
	// while the pointer moves on; writes to 3F7 never touch the view
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n)
			o_io_rdata <= 8'h00;
		else if (i_clk_en && rd_pulse) begin
			if (i_io_addr == `FRS_ADDR_RATE_CFG) begin
				case (o_register_mode)
				`FRS_MODE_EXT: o_io_rdata <= {~swap_sync[1], 4'hF, rate_code,
						~o_density_out};
				`FRS_MODE_CMP: o_io_rdata <= {~swap_sync[1], 3'h0,
						i_request_gate_flag, precomp_off_flag, rate_code};
				default:       o_io_rdata <= {~swap_sync[1], 7'h00};
				endcase
			end else if (i_io_addr == `FRS_ADDR_DATA)
				o_io_rdata <= (result_left == `FRS_RESULT_COUNT) ? result_zero : result_one;
			else
				o_io_rdata <= 8'h00;
		end
	end

	// Drive the bus only while a mapped address is being read
	assign o_io_rdata_oe = ~rd_sync[1] & ~i_io_rd_n &
		((i_io_addr == `FRS_ADDR_RATE_CFG) | (i_io_addr == `FRS_ADDR_DATA));
endmodule // frs_rate_status_regs

// ===== rtl/frs_status_pack.v
`include "frs_consts.vh"

// Packs the two result status bytes from event and state inputs
module frs_status_pack (
	input  wire [1:0] i_completion_code,    // Completion code
	input  wire       i_positioning_done,   // Seek/recalibrate finished
	input  wire       i_drive_fault_flag,   // Track zero not reached, or seek past track zero
	input  wire       i_head,               // Current head
	input  wire [1:0] i_unit_number,        // Selected drive
	input  wire       i_end_of_track,       // Past final sector or no end count
	input  wire       i_crc_fault,          // CRC error
	input  wire       i_overrun,            // Service too late
	input  wire       i_sector_absent,      // Sector not found
	input  wire       i_write_blocked,      // Write protect hit
	input  wire       i_no_sync_pattern,    // Address mark missing
	output wire [7:0] o_status_zero,        // Result byte 0
	output wire [7:0] o_status_one          // Result byte 1
);
	// Bit 3 unused, held zero
	assign o_status_zero = {i_completion_code,
		i_positioning_done,
		i_drive_fault_flag,
		1'b0,
		i_head, i_unit_number};
	// Bits 6 and 3 unused, held zero
	assign o_status_one = {i_end_of_track,
		1'b0,
		i_crc_fault,
		i_overrun,
		1'b0,
		i_sector_absent,
		i_write_blocked,
		i_no_sync_pattern};
endmodule // frs_status_pack

// ===== testbench/frs_host_model.sv
// Host side of the I/O bus: fixed strobe timing, no ready handshake
module frs_host_model (
	input  wire       i_sys_clk, // Bus clock
	input  wire [7:0] i_rdata,   // Read data from device
	output reg  [9:0] o_addr,    // I/O address
	output reg        o_rd_n,    // Read strobe, active low
	output reg        o_wr_n,    // Write strobe, active low
	output reg  [7:0] o_wdata    // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_addr = 10'h000;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_wdata = 8'h00;
	end
	// Strobe low 4 cycles, then high 4; data held past the sync window
	task io_write(input [9:0] a, input [7:0] d);
		@(negedge i_sys_clk);
		o_addr = a;
		o_wdata = d;
		o_wr_n = 1'b0;
		repeat (4) @(negedge i_sys_clk);
		o_wr_n = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		o_wdata = ~d; // Stale data must not linger on a released bus
	endtask
	// Data taken after the 3-cycle answer delay has surely passed
	task io_read(input [9:0] a, output [7:0] d);
		@(negedge i_sys_clk);
		o_addr = a;
		o_rd_n = 1'b0;
		repeat (5) @(negedge i_sys_clk);
		d = i_rdata;
		o_rd_n = 1'b1;
		repeat (4) @(negedge i_sys_clk);
	endtask
endmodule // frs_host_model

// ===== testbench/frs_rate_status_regs_assertions.sv
module frs_rate_status_regs_assertions (
	input wire       i_sys_clk,       // Clock
	input wire       i_reset_n,       // Hardware reset
	input wire [9:0] i_io_addr,       // Address
	input wire       i_io_rd_n,       // Read strobe
	input wire       i_io_wr_n,       // Write strobe
	input wire [7:0] i_config_mode,   // Mode byte
	input wire       i_exec_done,     // Execution end
	input wire [7:0] o_io_rdata,      // Read data
	input wire       o_io_rdata_oe,   // Drive enable
	input wire       o_density_out,   // Density pin
	input wire [3:0] o_rate_setting,  // Decoded rate
	input wire [1:0] o_register_mode, // Mode
	input wire       o_result_ready   // Result pending
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	density_cause_a: assert property ($changed(o_density_out) |-> !$past(i_io_wr_n, 3) && $past(i_io_addr, 3) == 10'h3F7)
		else $error("density moved without a rate write");
	rate_onehot_a: assert property ($onehot(o_rate_setting))
		else $error("rate setting not one-hot");
	mode_decode_a: assert property (o_register_mode == (i_config_mode[6] ? 2'h0 : i_config_mode[5] ? 2'h1 : 2'h2))
		else $error("register mode decode wrong");
	oe_address_a: assert property (o_io_rdata_oe |-> (i_io_addr == 10'h3F7 || i_io_addr == 10'h3F5))
		else $error("drive enable at foreign address");
	oe_after_read_a: assert property (o_io_rdata_oe |-> !$past(i_io_rd_n, 1) || !$past(i_io_rd_n, 2) || !$past(i_io_rd_n, 3))
		else $error("drive enable without read");
	rate_cause_a: assert property ($changed(o_rate_setting) |-> !$past(i_io_wr_n, 3) && $past(i_io_addr, 3) == 10'h3F7)
		else $error("rate changed without write");
	ext_ones_a: assert property (o_io_rdata_oe && $past(o_io_rdata_oe, 2) && i_io_addr == 10'h3F7 && o_register_mode == 2'h1 |-> o_io_rdata[6:3] == 4'hF)
		else $error("extended view bits not one");
	cmp_zeros_a: assert property (o_io_rdata_oe && $past(o_io_rdata_oe, 2) && i_io_addr == 10'h3F7 && o_register_mode == 2'h2 |-> o_io_rdata[6:4] == 3'h0)
		else $error("compact view bits not zero");
	result_ready_a: assert property (i_exec_done |=> o_result_ready)
		else $error("result not pending after execution");
endmodule // frs_rate_status_regs_assertions
bind frs_rate_status_regs frs_rate_status_regs_assertions frs_rate_status_regs_assertions_i (.i_sys_clk, .i_reset_n,
	.i_io_addr, .i_io_rd_n, .i_io_wr_n, .i_config_mode, .i_exec_done, .o_io_rdata, .o_io_rdata_oe, .o_density_out,
	.o_rate_setting, .o_register_mode, .o_result_ready);

// ===== testbench/frs_rate_status_regs_tb.sv
module frs_rate_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	reg        clk = 1'b0, reset_n = 1'b0, srst = 1'b0, gate = 1'b0, media = 1'b0, ex = 1'b0, p, s;
	reg        pd = 0, hd = 0, sb = 0, dc = 0, tc = 0, crc = 0, ov = 0, sa = 0, ns = 0, spz = 0;
	reg        ra = 0, sp = 0, tz = 1, wc = 0, wp = 0; // Track zero held active outside recalibrate
	reg  [1:0] cc = 2'h0, unit = 2'h0, rt;
	reg  [7:0] cfg = 8'h00, b0, b1, rd;
	wire [9:0] addr;
	wire [7:0] wdata, rdata;
	wire [3:0] rset;
	wire [1:0] rmode;
	wire       rd_n, wr_n, oe, dens, rready;
	integer    err_total = 0, comparisons = 0, cycles = 0, i, m;
	always #20 clk = ~clk;
	// Hang guard, far above the fewer than one thousand cycles of the run
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			stop_test;
		end
	end
	// Expected input status view per register mode
	function [7:0] view(input [1:0] md, input [1:0] r, input pr, g, chg);
		case (md)
			2'h1: view = {~chg, 4'hF, r, ~(r == 2'h0 || r == 2'h3)};
			2'h2: view = {~chg, 3'h0, g, pr, r};
			default: view = {~chg, 7'h00};
		endcase
	endfunction
	task check(input [7:0] seen, exp, input string msg);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task stop_test;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// End a command, then fetch both result bytes in order
	task finish_cmd;
		@(negedge clk) ex = 1'b1;
		@(negedge clk) ex = 1'b0;
		frs_host_model_i.io_read(10'h3F5, b0);
		frs_host_model_i.io_read(10'h3F5, b1);
	endtask
	frs_host_model frs_host_model_i (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_wdata(wdata));
	frs_rate_status_regs frs_rate_status_regs_i (.i_sys_clk(clk), .i_reset_n(reset_n), .i_clk_en(1'b1),
		.i_soft_reset(srst), .i_io_addr(addr), .i_io_rd_n(rd_n), .i_io_wr_n(wr_n), .i_io_wdata(wdata),
		.o_io_rdata(rdata), .o_io_rdata_oe(oe), .i_config_mode(cfg), .i_request_gate_flag(gate),
		.i_media_swapped(media), .o_density_out(dens), .o_rate_setting(rset), .o_register_mode(rmode),
		.i_exec_done(ex), .i_completion_code(cc), .i_positioning_done(pd), .i_recal_active(ra), .i_step_pulse(sp),
		.i_track_zero_in(tz), .i_seek_past_zero(spz), .i_head(hd), .i_unit_number(unit), .i_sector_beyond(sb),
		.i_data_cmd(dc), .i_transfer_end_in(tc), .i_crc_fault(crc), .i_overrun(ov), .i_sector_absent(sa),
		.i_write_cmd(wc), .i_write_protect_in(wp), .i_no_sync_pattern(ns), .o_result_ready(rready));
	initial begin
		b0 = $urandom(32'hBB05);
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		gate = $urandom;
		media = $urandom;
		repeat (6) @(negedge clk);
		check({7'h0, dens}, 8'h01, "density after reset");
		check({4'h0, rset}, 8'h04, "rate after reset");
		frs_host_model_i.io_read(10'h3F7, rd);
		check(rd, view(2'h2, 2'h2, 1'b0, gate, media), "compact after reset");
		// Every rate code, every mode; flags random
		for (i = 0; i < 8; i = i + 1) begin
			cfg = 8'h00;
			gate = $urandom;
			media = $urandom;
			p = $urandom;
			rt = i[1:0] + 2'h2;
			frs_host_model_i.io_write(10'h3F7, {5'h00, p, rt});
			check({4'h0, rset}, 8'h01 << rt, "rate setting");
			check({7'h0, dens}, {7'h0, rt == 2'h0 || rt == 2'h3}, "density");
			for (m = 0; m < 3; m = m + 1) begin
				cfg = $urandom;
				cfg[6] = (m == 0);
				if (m != 0) cfg[5] = (m == 1);
				frs_host_model_i.io_read(10'h3F7, rd);
				check(rd, view(m[1:0], rt, p, gate, media), "input view");
			end
		end
		// Soft reset keeps rate, flag and density (last rate is 300K)
		cfg = 8'h00;
		@(negedge clk) srst = 1'b1;
		@(negedge clk) srst = 1'b0;
		frs_host_model_i.io_read(10'h3F7, rd);
		check(rd, view(2'h2, rt, p, gate, media), "after soft reset");
		check({7'h0, dens}, 8'h00, "density after soft reset");
		frs_host_model_i.io_write(10'h3F2, 8'h03);
		check({4'h0, rset}, 8'h01 << rt, "foreign write");
		frs_host_model_i.io_read(10'h3F0, rd);
		check(rd, 8'h00, "unmapped read");
		// Result bytes with random fields, every completion code
		for (i = 0; i < 8; i = i + 1) begin
			cc = i[1:0];
			{pd, hd, sb, dc, tc, crc, ov, sa, ns, unit, s} = $urandom;
			@(negedge clk) spz = s;
			@(negedge clk) spz = 1'b0;
			finish_cmd;
			check(b0, {cc, pd, s, 1'b0, hd, unit}, "status zero");
			check(b1, {sb | (dc & ~tc), 1'b0, crc, ov, 1'b0, sa, 1'b0, ns}, "status one");
			check({7'h0, rready}, 8'h00, "result drained");
		end
		{cc, pd, hd, sb, dc, tc, crc, ov, sa, ns, unit} = 0;
		ra = 1'b1;
		tz = 1'b0;
		repeat (4) @(negedge clk); // Let the track zero synchroniser settle
		repeat (80) begin
			@(negedge clk) sp = 1'b1;
			@(negedge clk) sp = 1'b0;
		end
		repeat (4) @(negedge clk); // Hold recalibrate while the limit is seen
		ra = 1'b0;
		tz = 1'b1;
		finish_cmd;
		check(b0, 8'h10, "recalibrate fault");
		wc = 1'b1;
		@(negedge clk) wp = 1'b1;
		repeat (4) @(negedge clk);
		finish_cmd;
		check(b1, 8'h02, "write blocked");
		stop_test;
	end
endmodule // frs_rate_status_regs_tb
